// File: hw/tmr_consts.vh
/*
 Constants for the timer/counter with shared prescaler: register offsets,
 field positions, reset values and timing counts.
 Assumes a 100 MHz system clock; included by the timer design file by bare name.
*/
`ifndef TMR_CONSTS_VH
`define TMR_CONSTS_VH

`define ADDR_W            8
`define OFF_TIMER_COUNT   8'h01
`define OFF_INTR_CTRL     8'h0b
`define OFF_OPTION_CFG    8'h81
`define OFF_PORT_A_DIR    8'h85
`define OFF_WDT_CLEAR     8'h90
`define OFF_IRQ_STATUS    8'h91
`define OFF_IRQ_MASK      8'h92

`define OPTION_RESET      8'hff
`define PORT_A_DIR_RESET  8'h3f
`define PORT_A_DIR_MASK   8'h3f
`define INTR_CTRL_RESET   8'h00

`define OPT_RATIO_LSB     0
`define OPT_ASSIGN_BIT    3
`define OPT_EDGE_BIT      4
`define OPT_SOURCE_BIT    5
`define INTC_FLAG_BIT     2
`define INTC_ENABLE_BIT   5

`define CLK_PERIOD_NS     10
`define INSTR_CYCLE_CLKS  4
`define HOLD_OFF_INSTR    2
`define HOLD_OFF_CLKS     (`HOLD_OFF_INSTR * `INSTR_CYCLE_CLKS)

`endif

// File: hw/ripple_prescaler.v
/*
 Eight-stage divide-by-two chain that forms the shared prescaler.
 Assumes the count enable is a one-cycle pulse on the same clock; every
 stage is a toggle flip-flop so that each tap is a symmetrical square wave.
*/
`timescale 1ns/10ps
`default_nettype none

module ripple_prescaler
#(
  parameter WIDTH = 8
)
(
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             clr_i,
  input  wire             step_i,
  output wire [WIDTH-1:0] taps_o
);

  reg  [WIDTH-1:0] stage_r;
  wire [WIDTH:0]   carry;

  assign carry[0] = step_i;
  assign taps_o   = stage_r;

  // Each stage toggles when the stage below falls, like a ripple counter but on one clock.
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : stage_gen
      assign carry[g+1] = carry[g] & stage_r[g];
      always @(posedge clk_i)
      begin
        if (rst_i || clr_i)
          stage_r[g] <= 1'b0;
        else if (carry[g])
          stage_r[g] <= ~stage_r[g];
      end
    end
  endgenerate

endmodule

`default_nettype wire

// File: hw/timer_ext_clock_prescaler.v
/*
 Eight-bit timer/counter with an external count input and a shared
 prescaler that serves either the timer or the watchdog as a postscaler.
 Assumes a register port with a one-cycle read latency, a watchdog outside
 this block that takes the postscaler tap, and an asynchronous count pin.
*/
// Our own choice: the strobed register port.
// How it works
// - Without prescaler, the count input is sampled at the second and fourth phase.
// - Assigned to the timer, the prescaler divides the input to a symmetrical wave.
// - The timer increments only after the synchroniser, some phases after the edge.
// - One 8-bit counter serves timer or watchdog, never both at once.
// - Option bit 3 selects assignment, bits 2..0 the ratio.
// - Writing the count register clears the prescaler while it serves the timer.
// - The watchdog clear also clears the prescaler while it serves the watchdog.
// - Software can neither read nor write the prescaler count.
// - The assignment may change at any time without reset or halt.
// - Assignment bit clear gives ratios 1:2 to 1:256 in powers of two.
// - Source bit picks instruction cycles or pin edges; edge bit clear means rising.
// - A write to the count register holds off counting for two instruction cycles.
// - Rollover from ff to 00 sets the sticky overflow flag, enabled onto interrupt.
`timescale 1ns/10ps
`default_nettype none
`include "tmr_consts.vh"

module timer_ext_clock_prescaler
#(
  parameter PRESCALE_W = 8
)
(
  input  wire                 clk_i,
  input  wire                 rst_i,
  input  wire [`ADDR_W-1:0]   addr_i,
  input  wire [7:0]           wdata_i,
  input  wire                 wr_i,
  input  wire                 rd_i,
  output reg  [7:0]           rdata_o,
  input  wire                 ext_count_clock_pin_i,
  input  wire                 watchdog_clear_instr_i,
  output reg                  watchdog_tick_o,
  output reg                  watchdog_clear_o,
  output reg  [7:0]           port_a_direction_o,
  output reg                  irq_o
);

  // Hold-off length in clocks, sized to the hold-off counter.
  localparam [3:0]      HOLD_OFF = `HOLD_OFF_CLKS;

  // Phase counter: four clock phases make one instruction cycle.
  reg  [1:0]            phase_r;
  wire                  phase_q2 = (phase_r == 2'd1);
  wire                  phase_q4 = (phase_r == 2'd3);
  wire                  instr_end = phase_q4;

  reg  [7:0]            timer_count_reg_r;
  reg  [7:0]            option_r;
  reg  [7:0]            intc_r;
  reg  [7:0]            irq_status_r;
  reg  [7:0]            irq_mask_r;
  reg  [3:0]            hold_off_r;

  // Pin synchroniser: three flops, a change counts once stages two and three agree.
  reg                   pin_s1_r;
  reg                   pin_s2_r;
  reg                   pin_s3_r;
  reg                   pin_level_r;

  reg                   src_prev_r;
  reg                   tap_prev_r;
  reg                   tap_q2_r;
  reg                   tap_sync_r;
  reg                   tap_sync_prev_r;

  wire                  assign_wdt   = option_r[`OPT_ASSIGN_BIT];
  wire                  edge_fall    = option_r[`OPT_EDGE_BIT];
  wire                  source_pin   = option_r[`OPT_SOURCE_BIT];
  wire [2:0]            ratio_sel    = option_r[`OPT_RATIO_LSB+2:`OPT_RATIO_LSB];

  wire                  wr_count     = wr_i && (addr_i == `OFF_TIMER_COUNT);
  wire                  wr_option    = wr_i && (addr_i == `OFF_OPTION_CFG);
  wire                  wr_intc      = wr_i && (addr_i == `OFF_INTR_CTRL);
  wire                  wr_wdt_clr   = wr_i && (addr_i == `OFF_WDT_CLEAR);
  wire                  wdt_clear    = watchdog_clear_instr_i || wr_wdt_clr;

  // Edge of the chosen source, in the polarity the edge bit asks for.
  wire                  src_level    = source_pin ? (pin_level_r ^ edge_fall) : instr_end;
  wire                  src_edge     = source_pin ? (src_level && !src_prev_r) : instr_end;

  // Prescaler clears only for the party it serves.
  wire                  pre_clr      = (wr_count && !assign_wdt) || (wdt_clear && assign_wdt);
  wire [PRESCALE_W-1:0] taps;

  // The count is only reachable through clears, never through the register port.
  ripple_prescaler
  #(
    .WIDTH (PRESCALE_W)
  )
  u_prescaler
  (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .clr_i  (pre_clr),
    .step_i (src_edge),
    .taps_o (taps)
  );

  // Timer gets the selected tap or the raw source; the watchdog takes the same selected tap.
  wire                  sel_tap      = taps[ratio_sel];
  wire                  timer_pre    = assign_wdt ? src_level : sel_tap;
  wire                  wdt_tap      = taps[ratio_sel];

  reg                   wdt_tap_prev_r;

  // Instruction phase generator.
  always @(posedge clk_i)
  begin
    if (rst_i)
      phase_r <= 2'd0;
    else
      phase_r <= phase_r + 2'd1;
  end

  // Three-flop synchroniser with agreement filter on the pin.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_s1_r    <= 1'b0;
      pin_s2_r    <= 1'b0;
      pin_s3_r    <= 1'b0;
      pin_level_r <= 1'b0;
      src_prev_r  <= 1'b1; // Reset option picks the falling edge, so the idle source level is high.
    end
    else
    begin
      pin_s1_r   <= ext_count_clock_pin_i;
      pin_s2_r   <= pin_s1_r;
      pin_s3_r   <= pin_s2_r;
      src_prev_r <= src_level;
      if (pin_s2_r == pin_s3_r)
        pin_level_r <= pin_s3_r;
    end
  end

  // Prescaler output sampled at the second phase and again at the fourth, so
  // the timer sees at most one step per instruction cycle.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tap_q2_r        <= 1'b1; // Matches the idle source level so no false step follows reset.
      tap_sync_r      <= 1'b1;
      tap_sync_prev_r <= 1'b0;
      tap_prev_r      <= 1'b0;
    end
    else
    begin
      tap_prev_r <= timer_pre;
      if (phase_q2)
        tap_q2_r <= timer_pre;
      if (phase_q4)
      begin
        tap_sync_r      <= tap_q2_r;
        tap_sync_prev_r <= tap_sync_r;
      end
    end
  end

  // Internal mode on the watchdog assignment counts each instruction cycle directly.
  wire inc_step = (!source_pin && assign_wdt) ? instr_end
                : (phase_q4 && tap_q2_r && !tap_sync_r);

  // Count register, write hold-off and rollover detection.
  wire rollover = inc_step && (hold_off_r == 4'd0) && (timer_count_reg_r == 8'hff) && !wr_count;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      timer_count_reg_r <= 8'h00;
      hold_off_r        <= 4'd0;
    end
    else if (wr_count)
    begin
      timer_count_reg_r <= wdata_i;
      hold_off_r        <= HOLD_OFF;
    end
    else
    begin
      if (hold_off_r != 4'd0)
        hold_off_r <= hold_off_r - 4'd1;
      else if (inc_step)
        timer_count_reg_r <= timer_count_reg_r + 8'h01;
    end
  end

  // Option, direction and mask registers; the option may change at any time.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      option_r           <= `OPTION_RESET;
      port_a_direction_o <= `PORT_A_DIR_RESET;
      irq_mask_r         <= 8'h00;
    end
    else if (wr_i)
    begin
      if (wr_option)
        option_r <= wdata_i;
      if (addr_i == `OFF_PORT_A_DIR)
        port_a_direction_o <= wdata_i & `PORT_A_DIR_MASK;
      if (addr_i == `OFF_IRQ_MASK)
        irq_mask_r <= {7'h00, wdata_i[0]};
    end
  end

  // Control bits plus the sticky overflow flag; a rollover beats a software clear.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      intc_r       <= `INTR_CTRL_RESET;
      irq_status_r <= 8'h00;
    end
    else
    begin
      if (wr_intc)
        intc_r <= wdata_i;
      if (rollover)
        intc_r[`INTC_FLAG_BIT] <= 1'b1;
      if (wr_i && addr_i == `OFF_IRQ_STATUS)
        irq_status_r <= irq_status_r & ~{7'h00, wdata_i[0]};
      if (rollover)
        irq_status_r[0] <= 1'b1;
    end
  end

  // Interrupt: flag with its enable, or the sticky status through the mask.
  always @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= (intc_r[`INTC_FLAG_BIT] && intc_r[`INTC_ENABLE_BIT]) ||
               |(irq_status_r & irq_mask_r);
  end

  // Watchdog side: one tick per rising postscaler tap when assigned there.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wdt_tap_prev_r   <= 1'b0;
      watchdog_tick_o  <= 1'b0;
      watchdog_clear_o <= 1'b0;
    end
    else
    begin
      wdt_tap_prev_r   <= wdt_tap;
      watchdog_tick_o  <= assign_wdt && wdt_tap && !wdt_tap_prev_r;
      watchdog_clear_o <= wdt_clear;
    end
  end

  // Read port: data in the cycle after the strobe; unmapped reads return zero.
  always @(posedge clk_i)
  begin
    if (rst_i)
      rdata_o <= 8'h00;
    else if (rd_i)
    begin
      case (addr_i)
        `OFF_TIMER_COUNT: rdata_o <= timer_count_reg_r;
        `OFF_INTR_CTRL:   rdata_o <= intc_r;
        `OFF_OPTION_CFG:  rdata_o <= option_r;
        `OFF_PORT_A_DIR:  rdata_o <= port_a_direction_o;
        `OFF_IRQ_STATUS:  rdata_o <= irq_status_r;
        `OFF_IRQ_MASK:    rdata_o <= irq_mask_r;
        default:          rdata_o <= 8'h00;
      endcase
    end
    else
      rdata_o <= 8'h00;
  end

endmodule

`default_nettype wire

// File: dv/count_source_model.sv
/* Behavioural source on the external count pin.
   Assumes a start pulse and burst length given on the bench clock. */
`timescale 1ns/10ps
`default_nettype none
module count_source_model
(
  input  wire logic       clk_i,
  input  wire logic       start_i,
  input  wire logic [8:0] pulses_i,
  output var  logic       pin_o
);
  // The pin idles low between bursts, so no stray edge reaches the timer.
  initial
    pin_o = 1'b0;
  // Each level lasts 80 ns, well above the minimum high, low and period.
  always @(posedge clk_i)
  begin
    if (start_i)
    begin
      repeat (pulses_i)
      begin
        pin_o <= 1'b1;
        repeat (8) @(posedge clk_i);
        pin_o <= 1'b0;
        repeat (8) @(posedge clk_i);
      end
    end
  end
endmodule
`default_nettype wire

// File: dv/tmr_monitor.sv
/* Port checker for the timer block.
   Assumes it is bound onto timer_ext_clock_prescaler. */
`timescale 1ns/10ps
`default_nettype none
module tmr_monitor
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       watchdog_clear_instr_i,
  input wire logic       watchdog_tick_o,
  input wire logic       watchdog_clear_o,
  input wire logic [7:0] port_a_direction_o
);
  logic [7:0] opt_r;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Shadow of the option register, so tick ownership can be judged.
  always @(posedge clk_i)
  begin
    if (rst_i)
      opt_r <= 8'hff;
    else if (wr_i && addr_i == 8'h81)
      opt_r <= wdata_i;
  end
  property p_rd_quiet;
    rdata_o != 8'h00 |-> $past(rd_i);
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside answer");
  property p_unmapped;
    rd_i && addr_i == 8'h20 |=> rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_opt_read;
    rd_i && addr_i == 8'h81 |=> rdata_o == $past(opt_r);
  endproperty
  a_opt_read: assert property (p_opt_read) else $error("option read wrong");
  property p_clr_fwd;
    watchdog_clear_instr_i |=> watchdog_clear_o;
  endproperty
  a_clr_fwd: assert property (p_clr_fwd) else $error("watchdog clear lost");
  property p_clr_cause;
    watchdog_clear_o |-> $past(watchdog_clear_instr_i) || ($past(wr_i) && $past(addr_i) == 8'h90);
  endproperty
  a_clr_cause: assert property (p_clr_cause) else $error("spurious watchdog clear");
  property p_porta_wr;
    wr_i && addr_i == 8'h85 |=> port_a_direction_o == ($past(wdata_i) & 8'h3f);
  endproperty
  a_porta_wr: assert property (p_porta_wr) else $error("direction write wrong");
  property p_porta_hold;
    !(wr_i && addr_i == 8'h85) |=> $stable(port_a_direction_o);
  endproperty
  a_porta_hold: assert property (p_porta_hold) else $error("direction changed unasked");
  property p_count_holdoff;
    logic [7:0] v;
    (wr_i && addr_i == 8'h01, v = wdata_i) ##[1:6] (rd_i && addr_i == 8'h01) |=> rdata_o == v;
  endproperty
  a_count_holdoff: assert property (p_count_holdoff) else $error("count moved in hold-off");
  property p_tick_owner;
    watchdog_tick_o |-> opt_r[3] || $past(opt_r[3]);
  endproperty
  a_tick_owner: assert property (p_tick_owner) else $error("tick while timer owns divider");
endmodule
bind timer_ext_clock_prescaler tmr_monitor tmr_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .watchdog_clear_instr_i(watchdog_clear_instr_i), .watchdog_tick_o(watchdog_tick_o),
  .watchdog_clear_o(watchdog_clear_o), .port_a_direction_o(port_a_direction_o));
`default_nettype wire

// File: dv/testbench.sv
/* Self-checking bench for the timer with shared prescaler.
   Assumes the design, its header, the pin source model and the checker. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module testbench;
  logic       clk_i = 0;
  logic       rst_i = 1;
  logic [7:0] addr_i = 0;
  logic [7:0] wdata_i = 0;
  logic       wr_i = 0;
  logic       rd_i = 0;
  logic       wdog_clr = 0;
  logic       go = 0;
  logic [8:0] npulse = 0;
  logic       rd_q = 0;
  logic [7:0] exp_q[$];
  logic [7:0] v;
  logic [7:0] exp_v;
  wire logic [7:0] rdata_o;
  wire logic [7:0] pa_dir;
  wire logic       pin;
  wire logic       irq_o;
  int         n_mismatch = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  int         seed = 32'hdb955a2c;
  timer_ext_clock_prescaler timer_ext_clock_prescaler_inst (.clk_i(clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .ext_count_clock_pin_i(pin), .watchdog_clear_instr_i(wdog_clr), .watchdog_tick_o(),
    .watchdog_clear_o(), .port_a_direction_o(pa_dir), .irq_o(irq_o));
  count_source_model count_source_model_inst (.clk_i(clk_i), .start_i(go), .pulses_i(npulse), .pin_o(pin));
  // Free-running 100 MHz clock.
  always #5 clk_i = ~clk_i;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask
  task automatic wclr();
    @(posedge clk_i);
    wdog_clr <= 1'b1;
    @(posedge clk_i);
    wdog_clr <= 1'b0;
  endtask
  // The wait covers the whole burst plus the synchroniser delay.
  task automatic pulse(input logic [8:0] n);
    @(posedge clk_i);
    npulse <= n;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (16 * n + 24) @(posedge clk_i);
  endtask
  // Clearing the count before the watchdog, then reassigning, avoids a false reset.
  task automatic setup(input logic [7:0] opt);
    wr(8'h01, 8'h00);
    wclr();
    wr(8'h81, opt);
    wr(8'h01, 8'h00);
    rd(8'h01, 8'h00);
  endtask
  task automatic irq_step(input logic [7:0] a, input logic [7:0] d, input logic e);
    wr(a, d);
    @(posedge clk_i);
    #1;
    `CHK("irq", e, irq_o)
  endtask
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Read answers are compared one cycle after the strobe, oldest note first.
  always @(posedge clk_i)
  begin
    rd_q <= rd_i;
    if (rd_q)
    begin
      exp_v = exp_q.pop_front();
      `CHK("rdata", exp_v, rdata_o)
    end
    cyc++;
    if (cyc == 40000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // Main sequence.
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h81, 8'hff);
    rd(8'h85, 8'h3f);
    rd(8'h0b, 8'h00);
    rd(8'h20, 8'h00);
    v = $random(seed);
    wr(8'h85, v);
    rd(8'h85, v & 8'h3f);
    v = $random(seed);
    wr(8'h81, v);
    rd(8'h81, v);
    for (int e = 0; e < 2; e++)
    begin
      setup(e ? 8'h38 : 8'h28);
      pulse(9'd5);
      rd(8'h01, 8'h05);
    end
    for (int r = 0; r < 8; r++)
    begin
      setup(8'h20 | 8'(r));
      pulse(9'h001 << r);
      wr(8'h01, 8'h00);
      pulse(9'h001 << r);
      rd(8'h01, 8'h01);
      pulse(9'h002 << r);
      rd(8'h01, 8'h02);
    end
    setup(8'h08);
    wr(8'h92, 8'h00);
    wr(8'h0b, 8'h00);
    wr(8'h01, 8'hfe);
    rd(8'h01, 8'hfe);
    repeat (3) @(posedge clk_i);
    rd(8'h01, 8'hfe);
    repeat (40) @(posedge clk_i);
    wr(8'h81, 8'h28);
    rd(8'h0b, 8'h04);
    rd(8'h91, 8'h01);
    wr(8'h0b, 8'h00);
    irq_step(8'h92, 8'h01, 1'b1);
    irq_step(8'h92, 8'h00, 1'b0);
    irq_step(8'h92, 8'h01, 1'b1);
    irq_step(8'h91, 8'h01, 1'b0);
    wr(8'h90, 8'h01);
    repeat (4) @(posedge clk_i);
    report_and_stop();
  end
endmodule
`default_nettype wire
